// File: common/cell_meas_cfg.svh
// constants of the measurement mode sequencer
// assumes word-aligned AXI4-Lite registers and 16-bit results
`ifndef CELL_MEAS_CFG_SVH
`define CELL_MEAS_CFG_SVH
`define A_PAPP 8'h00
`define A_SAPP 8'h04
`define A_SYNC 8'h08
`define A_CFG 8'h0c
`define A_STAT 8'h10
`define A_CNT 8'h14
`define A_IDX 8'h18
`define A_APPRES 2'b01
`define A_SECRES 2'b10
`define A_PRIRES 2'b11
`define B_PAUSE 10
`define B_SYNC 0
`define B_FAST 1
`define B_SPAUSE 2
`define B_MEASEN 0
`define B_CYCP 1
`define B_FAPP_P 8
`define B_FAPP_S 9
`define INVALID 16'h8000
`define CNT_MIN 17'h00010
`define CNT_MAX 17'h0ffff
`define CNT_OVR 17'h10000
`define FAST_LEN 9'h01c
`define N_APP 10
`define N_TERM 18
`define RESP_OK 2'b00
`define RESP_ERR 2'b10
`endif

// File: common/cell_meas_pkg.sv
// types of the measurement mode sequencer
// assumes cell_meas_cfg.svh for numbers
package cell_meas_pkg;
    typedef enum logic [1:0] {
        SQ_IDLE = 2'b00,
        SQ_PAUSE = 2'b01,
        SQ_WAIT = 2'b10,
        SQ_RUN = 2'b11
    } seq_state_t;
    // converter strobes and samples
    typedef struct packed {
        logic scan;
        logic tick;
        logic period_start;
        logic [8:0] period_len;
        logic [15:0] pri_sample;
        logic [15:0] sec_sample;
    } adc_in_t;
endpackage

// File: core/cell_meas_mode_sequencer.sv
// measurement mode sequencer: app capture, sync and fast terminal runs
// assumes one 200 MHz clock, synchronous inputs, AXI4-Lite master
//
// Chosen here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "cell_meas_cfg.svh"
module cell_meas_mode_sequencer (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic [7:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [7:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    input wire cell_meas_pkg::adc_in_t ADC,
    input wire logic [159:0] APP_SAMPLES,
    input wire logic [17:0] CELL_ENABLE,
    input wire logic ACTIVE_ENTRY,
    input wire logic INVAL_FAULT,
    input wire logic CYCLIC_ENTRY,
    input wire logic CYCLIC_MEAS,
    output logic [4:0] SEC_TERMINAL,
    output logic SEC_BUSY,
    output logic BALANCE_PAUSE
);
    import cell_meas_pkg::*;

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    logic [10:0] papp_reg; // primary_app_control
    logic [10:0] sapp_reg; // secondary_app_control
    logic [9:0] cfg_reg; // enable, cyclic pause, pause length, fault options
    logic [16:0] cnt_reg [`N_APP]; // scans since last capture
    logic [31:0] sum_reg [`N_APP]; // running sums
    logic [9:0] armed_reg; // capture seen once
    logic [15:0] app_res_reg [`N_APP];
    logic [15:0] vc_cnt_reg; // app_cell_sample_count
    logic [15:0] sec_res_reg [`N_TERM]; // secondary_sync_terminal_result
    logic [15:0] pri_res_reg [`N_TERM];
    logic [15:0] idx_reg; // sync cycle index
    logic sync_rdy_reg, fast_rdy_reg;
    seq_state_t st_reg;
    logic fast_reg; // current run is a fast one
    logic req_sync_reg, req_fast_reg;
    logic [4:0] term_reg;
    logic [8:0] nsmp_reg; // samples taken on this terminal
    logic [8:0] plen_reg; // samples per terminal for this run
    logic [31:0] ssum_reg, psum_reg;
    logic [8:0] pcnt_reg; // primary scans during this terminal
    logic [3:0] pwait_reg; // pause settling countdown
    logic cyc_pend_reg;
    logic bvalid_reg, rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;

    // ----------------------------------------------------------------
    // bus handshake
    // ----------------------------------------------------------------
    logic wr_go, rd_go, cap_wr;
    logic [9:0] cap_mask;
    logic kill_all;
    assign wr_go = AWVALID & WVALID & ~bvalid_reg; // both channels together
    assign rd_go = ARVALID & ~rvalid_reg;
    assign AWREADY = wr_go;
    assign WREADY = wr_go;
    assign ARREADY = rd_go;
    assign BVALID = bvalid_reg;
    assign BRESP = `RESP_OK;
    assign RVALID = rvalid_reg;
    assign RDATA = rdata_reg;
    assign RRESP = rresp_reg;
    // capture bits: primary 5:0, secondary 9:6
    always_comb begin
        cap_mask = '0;
        if (wr_go && AWADDR == `A_PAPP && WSTRB[0]) begin
            cap_mask[5:0] = WDATA[5:0];
        end
        if (wr_go && AWADDR == `A_SAPP && WSTRB[1]) begin
            cap_mask[9:6] = WDATA[9:6];
        end
    end
    assign cap_wr = |cap_mask;
    // disable or active entry wipes results
    assign kill_all = ACTIVE_ENTRY | (wr_go && AWADDR == `A_CFG && WSTRB[0]
        && !WDATA[`B_MEASEN] && cfg_reg[`B_MEASEN]);

    // write response and control registers
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            bvalid_reg <= 1'b0;
            papp_reg <= '0;
            sapp_reg <= '0;
            cfg_reg <= '0;
        end else begin
            if (wr_go) begin
                bvalid_reg <= 1'b1;
            end else if (BREADY) begin
                bvalid_reg <= 1'b0;
            end
            if (wr_go && AWADDR == `A_PAPP) begin
                papp_reg <= WDATA[10:0];
            end
            if (wr_go && AWADDR == `A_SAPP) begin
                sapp_reg <= WDATA[10:0];
            end
            if (wr_go && AWADDR == `A_CFG) begin
                cfg_reg <= WDATA[9:0];
            end
        end
    end

    // read path: unmapped register and app result addresses answer slave error, secondary slot 15 reads zero
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= `RESP_OK;
        end else if (rd_go) begin
            rvalid_reg <= 1'b1;
            rresp_reg <= `RESP_OK;
            rdata_reg <= '0;
            unique case (ARADDR[7:6])
                2'b00: begin
                    case (ARADDR)
                        `A_PAPP: rdata_reg <= {21'h0, papp_reg};
                        `A_SAPP: rdata_reg <= {21'h0, sapp_reg};
                        `A_CFG: rdata_reg <= {22'h0, cfg_reg};
                        `A_STAT: rdata_reg <= {18'h0, fast_rdy_reg, sync_rdy_reg,
                            ready_bits(cnt_reg, armed_reg)};
                        `A_CNT: rdata_reg <= {16'h0, vc_cnt_reg};
                        `A_IDX: rdata_reg <= {16'h0, idx_reg};
                        default: rresp_reg <= `RESP_ERR;
                    endcase
                end
                `A_APPRES: begin
                    if (ARADDR[5:2] < 4'(`N_APP)) begin
                        rdata_reg <= {16'h0, app_res_reg[ARADDR[5:2]]};
                    end else begin
                        rresp_reg <= `RESP_ERR;
                    end
                end
                `A_SECRES: begin
                    if (ARADDR[5:2] != 4'hf) begin
                        rdata_reg <= {16'h0, sec_res_reg[ARADDR[5:2]]};
                    end
                end
                `A_PRIRES: begin
                    rdata_reg <= {16'h0, pri_res_reg[ARADDR[5:2]]};
                end
            endcase
        end else if (RREADY) begin
            rvalid_reg <= 1'b0;
        end
    end

    // status: app k ready once more than 16 scans since capture, on bit k for k < 6 and bit k+1 for k >= 6
    function automatic logic [11:0] ready_bits(input logic [16:0] c [`N_APP],
        input logic [9:0] a);
        logic [11:0] r;
        r = '0;
        for (int i = 0; i < `N_APP; i++) begin
            r[(i < 6) ? i : i + 1] = a[i] && c[i] > `CNT_MIN;
        end
        return r;
    endfunction

    // ----------------------------------------------------------------
    // application timed averaging
    // ----------------------------------------------------------------
    // the divide is wide but runs only on a capture; fine at 200 MHz
    // only with a multicycle path, a trade for area
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            armed_reg <= '0;
            vc_cnt_reg <= '0;
            for (int i = 0; i < `N_APP; i++) begin
                cnt_reg[i] <= '0;
                sum_reg[i] <= '0;
                app_res_reg[i] <= `INVALID;
            end
        end else begin
            for (int i = 0; i < `N_APP; i++) begin
                if (kill_all) begin
                    app_res_reg[i] <= `INVALID;
                end else if (cap_mask[i]) begin
                    if (cnt_reg[i] < `CNT_MIN || cnt_reg[i] > `CNT_MAX) begin
                        app_res_reg[i] <= `INVALID;
                    end else begin
                        app_res_reg[i] <= 16'(sum_reg[i] / 32'(cnt_reg[i]));
                    end
                end else if (rd_go && ARADDR[7:6] == `A_APPRES
                    && ARADDR[5:2] == 4'(i)) begin
                    app_res_reg[i] <= `INVALID;
                end else if (INVAL_FAULT && i >= 1 && i < 6 && cfg_reg[`B_FAPP_P]) begin
                    app_res_reg[i] <= `INVALID;
                end else if (INVAL_FAULT && i >= 6 && cfg_reg[`B_FAPP_S]) begin
                    app_res_reg[i] <= `INVALID;
                end
                if (cap_mask[i]) begin
                    armed_reg[i] <= cfg_reg[`B_MEASEN];
                    cnt_reg[i] <= '0;
                    sum_reg[i] <= '0;
                end else if (ADC.scan && armed_reg[i] && cnt_reg[i] != `CNT_OVR) begin
                    cnt_reg[i] <= cnt_reg[i] + 17'h1;
                    sum_reg[i] <= sum_reg[i] + 32'(APP_SAMPLES[i*16 +: 16]);
                end
                if (!cfg_reg[`B_MEASEN]) begin
                    armed_reg[i] <= 1'b0;
                end
            end
            if (cap_mask[0]) begin
                vc_cnt_reg <= (cnt_reg[0] > `CNT_MAX) ? 16'hffff
                    : cnt_reg[0][15:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // balancing pause
    // ----------------------------------------------------------------
    logic app_pause, seq_pause, cyc_pause;
    logic plen_pause_reg; // current run asked for a pause
    assign app_pause = (papp_reg[`B_PAUSE] & |armed_reg[5:0])
        | (sapp_reg[`B_PAUSE] & |armed_reg[9:6]);
    assign cyc_pause = cfg_reg[`B_CYCP] & (CYCLIC_MEAS | cyc_pend_reg);
    assign seq_pause = plen_pause_reg & (st_reg != SQ_IDLE);
    // held until the last pausing sequence ends
    assign BALANCE_PAUSE = app_pause | cyc_pause | seq_pause;

    // cyclic wake pause lasts until the first cyclic measurement
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            cyc_pend_reg <= 1'b0;
        end else if (CYCLIC_ENTRY) begin
            cyc_pend_reg <= 1'b1;
        end else if (CYCLIC_MEAS) begin
            cyc_pend_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // sync / fast terminal sequencer
    // ----------------------------------------------------------------
    logic [4:0] nxt_term;
    logic term_done, run_start;
    // next enabled terminal above the current one, 5'h1f if none
    always_comb begin
        nxt_term = 5'h1f;
        for (int t = `N_TERM - 1; t >= 0; t--) begin
            if (CELL_ENABLE[t] && 5'(t) > term_reg) begin
                nxt_term = 5'(t);
            end
        end
    end
    assign term_done = st_reg == SQ_RUN && ADC.tick && nsmp_reg + 9'h1 == plen_reg;
    assign SEC_TERMINAL = term_reg;
    assign SEC_BUSY = st_reg == SQ_RUN;
    assign run_start = st_reg == SQ_WAIT && (fast_reg ? ADC.scan : ADC.period_start);
    // lowest enabled terminal, 5'h1e if none; the upward search cannot start from 5'h1f
    logic [4:0] nxt_term_first;
    always_comb begin
        nxt_term_first = 5'h1e;
        for (int t = `N_TERM - 1; t >= 0; t--) begin
            if (CELL_ENABLE[t]) begin
                nxt_term_first = 5'(t);
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            st_reg <= SQ_IDLE;
            fast_reg <= 1'b0;
            req_sync_reg <= 1'b0;
            req_fast_reg <= 1'b0;
            plen_pause_reg <= 1'b0;
            pwait_reg <= '0;
            term_reg <= '0;
            nsmp_reg <= '0;
            plen_reg <= '0;
            ssum_reg <= '0;
            psum_reg <= '0;
            pcnt_reg <= '0;
        end else begin
            if (wr_go && AWADDR == `A_SYNC && WSTRB[0]) begin
                req_sync_reg <= WDATA[`B_SYNC] & ~WDATA[`B_FAST];
                req_fast_reg <= WDATA[`B_FAST];
                plen_pause_reg <= WDATA[`B_SPAUSE];
            end
            unique case (st_reg)
                SQ_IDLE: begin
                    if ((req_sync_reg | req_fast_reg) && cfg_reg[`B_MEASEN]) begin
                        fast_reg <= req_fast_reg;
                        req_sync_reg <= 1'b0;
                        req_fast_reg <= 1'b0;
                        pwait_reg <= cfg_reg[7:4];
                        // already paused by someone else: no settling delay
                        st_reg <= (plen_pause_reg && !app_pause && !cyc_pause)
                            ? SQ_PAUSE : SQ_WAIT;
                    end
                end
                SQ_PAUSE: begin
                    if (ADC.scan) begin
                        if (pwait_reg == 4'h0) begin
                            st_reg <= SQ_WAIT;
                        end else begin
                            pwait_reg <= pwait_reg - 4'h1;
                        end
                    end
                end
                SQ_WAIT: begin
                    if (run_start) begin
                        st_reg <= SQ_RUN;
                        plen_reg <= fast_reg ? `FAST_LEN : ADC.period_len;
                        term_reg <= 5'h1f;
                        nsmp_reg <= 9'h0;
                        ssum_reg <= '0;
                        psum_reg <= '0;
                        pcnt_reg <= '0;
                    end
                end
                SQ_RUN: begin
                    if (term_reg == 5'h1f) begin
                        term_reg <= (CELL_ENABLE == '0) ? 5'h1e : nxt_term_first;
                    end else if (term_done || term_reg == 5'h1e) begin
                        nsmp_reg <= '0;
                        ssum_reg <= '0;
                        psum_reg <= '0;
                        pcnt_reg <= '0;
                        term_reg <= nxt_term;
                        if (nxt_term == 5'h1f || term_reg == 5'h1e) begin
                            st_reg <= SQ_IDLE;
                        end
                    end else if (ADC.tick) begin
                        nsmp_reg <= nsmp_reg + 9'h1;
                        ssum_reg <= ssum_reg + 32'(ADC.sec_sample);
                    end
                    // a scan on the terminal switch edge is dropped, not carried over
                    if (ADC.scan && !term_done && term_reg < 5'(`N_TERM)) begin
                        pcnt_reg <= pcnt_reg + 9'h1;
                        psum_reg <= psum_reg + 32'(ADC.pri_sample);
                    end
                end
            endcase
            if (!cfg_reg[`B_MEASEN] || ACTIVE_ENTRY) begin
                st_reg <= SQ_IDLE;
            end
        end
    end
    // sync and terminal result registers
    logic last_term;
    assign last_term = term_done && nxt_term == 5'h1f;
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            sync_rdy_reg <= 1'b0;
            fast_rdy_reg <= 1'b0;
            idx_reg <= '0;
            for (int t = 0; t < `N_TERM; t++) begin
                sec_res_reg[t] <= `INVALID;
                pri_res_reg[t] <= `INVALID;
            end
        end else begin
            if (run_start) begin
                sync_rdy_reg <= sync_rdy_reg & fast_reg;
                fast_rdy_reg <= fast_rdy_reg & ~fast_reg;
            end
            if (last_term || (st_reg == SQ_RUN && term_reg == 5'h1e)) begin
                if (fast_reg) begin
                    fast_rdy_reg <= 1'b1;
                end else begin
                    sync_rdy_reg <= 1'b1;
                    idx_reg <= idx_reg + 16'h1;
                end
            end
            for (int t = 0; t < `N_TERM; t++) begin
                if (kill_all || INVAL_FAULT) begin
                    sec_res_reg[t] <= `INVALID;
                end else if (term_done && term_reg == 5'(t)) begin
                    sec_res_reg[t] <= 16'((ssum_reg + 32'(ADC.sec_sample))
                        / 32'(plen_reg));
                end else if (rd_go && ARADDR[7:6] == `A_SECRES
                    && ARADDR[5:2] != 4'hf && {1'b0, ARADDR[5:2]} == 5'(t)) begin
                    sec_res_reg[t] <= `INVALID;
                end
                if (kill_all) begin
                    pri_res_reg[t] <= `INVALID;
                end else if (term_done && !fast_reg && term_reg == 5'(t)) begin
                    pri_res_reg[t] <= (pcnt_reg == '0) ? `INVALID
                        : 16'(psum_reg / 32'(pcnt_reg));
                end else if (rd_go && ARADDR[7:6] == `A_PRIRES
                    && {1'b0, ARADDR[5:2]} == 5'(t)) begin
                    pri_res_reg[t] <= `INVALID;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESETN);
    AST_CAP_SHORT: assert property (cap_mask[0] && cnt_reg[0] < `CNT_MIN && !kill_all
        |=> app_res_reg[0] == `INVALID) else $error("short capture kept");
    AST_CNT_SAT: assert property (cap_mask[0] && cnt_reg[0] > `CNT_MAX
        |=> vc_cnt_reg == 16'hffff) else $error("count not saturated");
    AST_CNT_ACT: assert property (cap_mask[0] && cnt_reg[0] <= `CNT_MAX
        |=> vc_cnt_reg == $past(cnt_reg[0][15:0])) else $error("count wrong");
    AST_READ_INV: assert property (rd_go && ARADDR == 8'h40 && !cap_mask[0]
        |=> app_res_reg[0] == `INVALID) else $error("read kept result");
    AST_KILL: assert property (kill_all |=> sec_res_reg[0] == `INVALID
        && pri_res_reg[0] == `INVALID && app_res_reg[9] == `INVALID)
        else $error("results survive disable");
    AST_FAULT_PRI: assert property (INVAL_FAULT && !kill_all && !term_done
        && !(rd_go && ARADDR[7:6] == `A_PRIRES)
        |=> pri_res_reg[0] == $past(pri_res_reg[0])) else $error("primary lost");
    AST_FAST_LEN: assert property (run_start && fast_reg |=> plen_reg == `FAST_LEN)
        else $error("fast length");
    AST_FAST_START: assert property (st_reg == SQ_WAIT && fast_reg && ADC.scan
        && cfg_reg[`B_MEASEN] && !ACTIVE_ENTRY
        |=> st_reg == SQ_RUN) else $error("fast start late");
    AST_PAUSE_HOLD: assert property (st_reg != SQ_IDLE && plen_pause_reg
        |-> BALANCE_PAUSE) else $error("balancing not paused");
    AST_SYNC_RDY: assert property (last_term && !fast_reg |=> sync_rdy_reg
        && idx_reg == $past(idx_reg) + 16'h1) else $error("sync ready");
    COV_SYNC: cover property (last_term && !fast_reg);
    COV_FAST: cover property (last_term && fast_reg);
    COV_CAP: cover property (cap_mask[0] && cnt_reg[0] > `CNT_MIN);
    COV_SKIP: cover property (st_reg == SQ_RUN && !CELL_ENABLE[3]);
endmodule

// File: dv/tb.sv
// testbench of the measurement mode sequencer: capture, fast, sync, invalidation
// assumes the sequencer package and its header on the include path
`timescale 1ns/100ps
`include "cell_meas_cfg.svh"
module tb;
    import cell_meas_pkg::*;
    logic CLK = 0, RESETN = 0, AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
    logic [7:0] AWADDR = 0, ARADDR = 0;
    logic [31:0] WDATA = 0, rd;
    logic [3:0] WSTRB = 4'hf;
    logic [159:0] APP_SAMPLES = 0;
    logic [17:0] CELL_ENABLE = '1;
    logic ACTIVE_ENTRY = 0, INVAL_FAULT = 0, CYCLIC_ENTRY = 0, CYCLIC_MEAS = 0;
    adc_in_t ADC = '0;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID, SEC_BUSY, BALANCE_PAUSE;
    logic [1:0] BRESP, RRESP, rr;
    logic [31:0] RDATA;
    logic [4:0] SEC_TERMINAL;
    logic [15:0] app_val, sec_val, pri_val;
    int num_errors = 0, n_tests = 0, n, cyc = 0;
    cell_meas_mode_sequencer DUT (.CLK(CLK), .RESETN(RESETN), .AWADDR(AWADDR),
        .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID),
        .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
        .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
        .RREADY(RREADY), .ADC(ADC), .APP_SAMPLES(APP_SAMPLES), .CELL_ENABLE(CELL_ENABLE),
        .ACTIVE_ENTRY(ACTIVE_ENTRY), .INVAL_FAULT(INVAL_FAULT), .CYCLIC_ENTRY(CYCLIC_ENTRY),
        .CYCLIC_MEAS(CYCLIC_MEAS), .SEC_TERMINAL(SEC_TERMINAL), .SEC_BUSY(SEC_BUSY),
        .BALANCE_PAUSE(BALANCE_PAUSE));
    // ---------------------------------------------
    // clock and converter strobes
    // ---------------------------------------------
    initial forever #2.5 CLK = ~CLK;
    // secondary sample every cycle, a period every 64 cycles
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        ADC.tick <= 1'b1;
        ADC.period_start <= (cyc % 64) == 0;
        ADC.period_len <= 9'h010;
    end
    // ---------------------------------------------
    // bus and stimulus tasks
    // ---------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            num_errors++;
        end
    endtask
    // write: address and data offered together, held until taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK) {AWADDR, WDATA, AWVALID, WVALID} <= {a, d, 2'b11};
        do @(posedge CLK); while (!(AWREADY && WREADY));
        {AWVALID, WVALID, BREADY} <= 3'b001;
        do @(posedge CLK); while (BVALID !== 1'b1);
        BREADY <= 1'b0;
    endtask
    task automatic rdr(input logic [7:0] a);
        @(posedge CLK) {ARADDR, ARVALID} <= {a, 1'b1};
        do @(posedge CLK); while (ARREADY !== 1'b1);
        {ARVALID, RREADY} <= 2'b01;
        do @(posedge CLK); while (RVALID !== 1'b1);
        rd = RDATA;
        rr = RRESP;
        RREADY <= 1'b0;
    endtask
    // one scan pulse every four cycles keeps the count exact
    task automatic scans(input int k);
        repeat (k) begin
            @(posedge CLK) ADC.scan <= 1'b1;
            @(posedge CLK) ADC.scan <= 1'b0;
            repeat (2) @(posedge CLK);
        end
    endtask
    // one-cycle event pulse: 0 fault, 1 active entry, 2 cyclic entry
    task automatic pulse(input int w);
        @(posedge CLK) {CYCLIC_ENTRY, ACTIVE_ENTRY, INVAL_FAULT} <= 3'(1 << w);
        @(posedge CLK) {CYCLIC_ENTRY, ACTIVE_ENTRY, INVAL_FAULT} <= 3'h0;
    endtask
    // poll a status bit, bounded
    task automatic wait_stat(input int b);
        for (int i = 0; i < 300; i++) begin
            scans(8);
            rdr(8'h10);
            if (rd[b] === 1'b1) break;
        end
    endtask
    // average of a constant sample is the sample; short intervals are invalid
    function automatic logic [31:0] exp_app(input int k, input logic [15:0] v);
        return (k < 16 || k > 65535) ? 32'h8000 : {16'h0, v};
    endfunction
    task automatic give_verdict;
        $display("checks %0d, errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // ---------------------------------------------
    // main sequence and watchdog
    // ---------------------------------------------
    initial begin
        #400000;
        num_errors++;
        give_verdict;
    end
    initial begin
        void'($urandom(32'hb3d20d2b));
        app_val = 16'($urandom_range(16'h7fff));
        sec_val = 16'($urandom_range(16'h7fff));
        pri_val = 16'($urandom_range(16'h7fff));
        APP_SAMPLES <= {10{app_val}};
        ADC.pri_sample <= pri_val;
        ADC.sec_sample <= sec_val;
        CELL_ENABLE <= 18'($urandom) | 18'h3;
        repeat (12) @(posedge CLK);
        RESETN <= 1'b1;
        rdr(8'h40); chk(rd, 32'h8000);
        rdr(8'h1c); chk({30'h0, rr}, 32'h2);
        wr(8'h0c, 32'h1);
        // random, too short and boundary intervals
        for (int k = 0; k < 3; k++) begin
            n = (k == 0) ? 17 + $urandom_range(30) : ((k == 1) ? 5 : 16);
            wr(8'h00, 32'h3f);
            scans(n);
            rdr(8'h10); chk({31'h0, rd[0]}, 32'(n > 16));
            wr(8'h00, 32'h3f);
            rdr(8'h40); chk(rd, exp_app(n, app_val));
            rdr(8'h14); chk(rd, 32'(n));
            rdr(8'h40); chk(rd, 32'h8000);
        end
        wr(8'h0c, 32'h101);
        wr(8'h00, 32'h3f);
        scans(20);
        wr(8'h00, 32'h3f);
        pulse(0);
        rdr(8'h44); chk(rd, 32'h8000);
        rdr(8'h40); chk(rd, {16'h0, app_val});
        wr(8'h08, 32'h2);
        scans(2); chk({31'h0, SEC_BUSY}, 32'h1);
        wait_stat(13); chk({31'h0, rd[13]}, 32'h1);
        rdr(8'h80); chk(rd, {16'h0, sec_val});
        rdr(8'h80); chk(rd, 32'h8000);
        wr(8'h08, 32'h5);
        repeat (2) @(posedge CLK);
        chk({31'h0, BALANCE_PAUSE}, 32'h1);
        wait_stat(12); chk({31'h0, rd[12]}, 32'h1);
        chk({31'h0, BALANCE_PAUSE}, 32'h0);
        rdr(8'hc0); chk(rd, {16'h0, pri_val});
        pulse(0);
        rdr(8'h84); chk(rd, 32'h8000);
        rdr(8'hc4); chk(rd, {16'h0, pri_val});
        pulse(1);
        rdr(8'hc8); chk(rd, 32'h8000);
        wr(8'h0c, 32'h3);
        pulse(2);
        @(posedge CLK) chk({31'h0, BALANCE_PAUSE}, 32'h1);
        give_verdict;
    end
endmodule
